// *** logic/cpu_exception_sequencer.sv ***
/*
 exception sequencer of the cpu core: resets, interrupt acceptance and
 mmu general exceptions, with status word, saved state, event codes,
 vector selection and fault address capture.
 assumes the pipeline flushes and loads new_pc on pc_load, and that the
 interrupt controller has already applied mask levels to irq_req.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - reset pins sampled each clock; power-on reset aborts all at once
// - manual reset begins only after the running memory access ends
// - entry sets privilege, hold, bank bits; hold blocks all interrupts but nmi with nmi_override set
// - reset writes code 000 or 020 and starts at a000_0000
// - any reset clears vector base and sets the interrupt mask to ones
// - power-on and manual reset drive reset pin low, state pins high
// - debug port reset command acts as a power-on reset with code 000, but leaves the reset and state pins alone
// - interrupts taken only at instruction end; pc and status saved
// - interrupt code into both event registers; branch to base plus 600
// - general exception saves state; miss to plus 400, else plus 100
// - mmu faults load fault address and page number into page entry high
// - miss updates way count: add one if all valid, else lowest invalid
// - miss writes 040 for read or 060 for write, vector plus 400
// - invalid entry records matching way, miss codes, vector plus 100
// - store to clean page records way, code 080, vector plus 100
// - protection by two-bit permission field per privilege mode
// - protection violation writes 0a0 or 0c0, vector plus 100
// - exception while held resets cpu state and jumps to reset address
module cpu_exception_sequencer #(
	parameter int WAYS = 4,
	parameter int RCW = 2
) (
	input logic clk,
	input logic rst,
	input logic power_on_reset_n,
	input logic manual_reset_n,
	input logic debug_reset_cmd,
	input logic mem_access_busy,
	input logic insn_done,
	input exc_seq_pkg::word_t current_pc,
	input logic irq_req,
	input logic irq_is_nmi,
	input exc_seq_pkg::evt_t irq_code,
	input logic nmi_override,
	input logic mmu_access_valid,
	input logic mmu_write,
	input exc_seq_pkg::word_t mmu_vaddr,
	input logic mmu_hit,
	input logic [RCW-1:0] mmu_hit_way,
	input logic mmu_entry_valid,
	input logic mmu_entry_dirty,
	input logic [1:0] mmu_entry_perm,
	input logic [WAYS-1:0] mmu_ways_valid,
	input logic sw_status_we,
	input exc_seq_pkg::word_t sw_status_data,
	input logic sw_vbr_we,
	input exc_seq_pkg::word_t sw_vbr_data,
	input logic sw_asid_we,
	input logic [exc_seq_pkg::ASID_W-1:0] sw_asid_data,
	output exc_seq_pkg::word_t status_word,
	output exc_seq_pkg::word_t saved_pc,
	output exc_seq_pkg::word_t saved_status,
	output exc_seq_pkg::word_t vector_base,
	output exc_seq_pkg::evt_t exc_event_code,
	output exc_seq_pkg::evt_t irq_event_code,
	output exc_seq_pkg::evt_t irq_event_code_b,
	output exc_seq_pkg::word_t fault_address,
	output exc_seq_pkg::word_t page_entry_high,
	output logic [RCW-1:0] way_replace_count,
	output exc_seq_pkg::word_t new_pc,
	output logic pc_load,
	output logic irq_ack,
	output logic cpu_init,
	output logic periph_init,
	output logic reset_output_pin,
	output logic cpu_state_pin_0,
	output logic cpu_state_pin_1
);
	import exc_seq_pkg::*;

	seq_state_t state_r, state_nxt;
	rst_kind_t kind_r;
	word_t sr_r, spc_r, ssr_r, vbr_r, tea_r, page_entry_high_r, new_pc_r;
	evt_t exc_event_code_r, irq_event_code_r, irq_event_code_b_r;
	logic [RCW-1:0] rc_r;
	logic pc_load_r, irq_ack_r, cpu_init_r, periph_init_r;
	logic rst_pin_r, state_pins_r;
	logic reset_req, pin_reset, bl, exc_take, exc_ok, double_fault, irq_take;
	logic reset_done;

	exc_seq_link_if #(.WAYS(WAYS), .RCW(RCW)) lk ();

	assign lk.por_n = power_on_reset_n;
	assign lk.man_n = manual_reset_n;
	assign lk.dbg_cmd = debug_reset_cmd;
	assign lk.mem_busy = mem_access_busy;
	assign lk.acc_valid = mmu_access_valid;
	assign lk.acc_write = mmu_write;
	assign lk.acc_hit = mmu_hit;
	assign lk.acc_entry_valid = mmu_entry_valid;
	assign lk.acc_dirty = mmu_entry_dirty;
	assign lk.acc_perm = mmu_entry_perm;
	assign lk.acc_way = mmu_hit_way;
	assign lk.ways_valid = mmu_ways_valid;
	assign lk.priv = sr_r[SR_MD_BIT];
	assign lk.rc_now = rc_r;

	reset_pin_sampler u_rst (
		.clk(clk),
		.rst(rst),
		.lk(lk)
	);

	mmu_fault_classifier #(.WAYS(WAYS), .RCW(RCW)) u_mmu (
		.lk(lk)
	);

	function automatic word_t vec_of(input word_t base, input word_t ofs);
		return base + ofs;
	endfunction : vec_of

	function automatic evt_t reset_code(input rst_kind_t k);
		return (k == RK_MANUAL) ? CODE_MANUAL : CODE_POR;
	endfunction : reset_code

	assign bl = sr_r[SR_BL_BIT];
	assign reset_req = lk.por_hold || lk.man_hold || lk.dbg_req;
	assign pin_reset = lk.por_hold || lk.man_hold;
	// resets first, then mmu exceptions, then interrupts
	assign exc_take = (state_r == ST_RUN) && !reset_req
		&& lk.fault;
	assign exc_ok = exc_take && !bl;
	assign double_fault = exc_take && bl;
	assign irq_take = (state_r == ST_RUN) && !reset_req && !lk.fault && irq_req
		&& insn_done && (!bl || (irq_is_nmi && nmi_override));
	assign reset_done = (state_r == ST_RESET) && !pin_reset;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN: begin
				if (reset_req) begin
					state_nxt = ST_RESET;
				end else if (exc_take || irq_take) begin
					state_nxt = ST_VECTOR;
				end
			end
			ST_RESET: begin
				if (!pin_reset) begin
					state_nxt = ST_VECTOR;
				end
			end
			ST_VECTOR: begin
				// the vector cycle takes nothing new, only resets
				state_nxt = reset_req ? ST_RESET : ST_RUN;
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			kind_r <= RK_POR;
		end else if (lk.por_hold) begin
			kind_r <= RK_POR;
		end else if (lk.man_hold) begin
			kind_r <= RK_MANUAL;
		end else if (lk.dbg_req) begin
			kind_r <= RK_DEBUG;
		end
	end

	// hardware entry beats a software write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sr_r <= SR_RESET;
		end else if (state_r == ST_RESET || double_fault) begin
			sr_r <= SR_RESET;
		end else if (exc_ok || irq_take) begin
			sr_r <= sr_r | SR_ENTRY_SET;
		end else if (sw_status_we) begin
			sr_r <= sw_status_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			vbr_r <= VBR_RESET;
		end else if (state_r == ST_RESET || double_fault) begin
			vbr_r <= VBR_RESET;
		end else if (sw_vbr_we) begin
			vbr_r <= sw_vbr_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spc_r <= '0;
			ssr_r <= '0;
		end else if (exc_ok || irq_take) begin
			spc_r <= current_pc;
			ssr_r <= sr_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			exc_event_code_r <= EVT_RESET;
		end else if (state_r == ST_RESET) begin
			exc_event_code_r <= reset_code(kind_r);
		end else if (exc_ok) begin
			exc_event_code_r <= lk.fault_code;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_event_code_r <= EVT_RESET;
			irq_event_code_b_r <= EVT_RESET;
		end else if (irq_take) begin
			irq_event_code_r <= irq_code;
			irq_event_code_b_r <= irq_code;
		end
	end

	// mmu registers survive a double fault
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tea_r <= '0;
			rc_r <= '0;
		end else if (exc_ok) begin
			tea_r <= mmu_vaddr;
			rc_r <= lk.rc_nxt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			page_entry_high_r <= PAGE_ENTRY_HIGH_RESET;
		end else if (exc_ok) begin
			// asid field left as it stood at the fault
			page_entry_high_r[31:PAGE_ENTRY_HIGH_VPN_LO] <= mmu_vaddr[31:PAGE_ENTRY_HIGH_VPN_LO];
		end else if (sw_asid_we) begin
			page_entry_high_r[ASID_W-1:0] <= sw_asid_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_load_r <= 1'b0;
			new_pc_r <= RESET_VECTOR;
		end else begin
			pc_load_r <= reset_done || exc_take || irq_take;
			if (reset_done || double_fault) begin
				new_pc_r <= RESET_VECTOR;
			end else if (exc_ok) begin
				new_pc_r <= vec_of(vbr_r, lk.tlb_miss ? OFS_TLB_MISS : OFS_GENERAL);
			end else if (irq_take) begin
				new_pc_r <= vec_of(vbr_r, OFS_IRQ);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_ack_r <= 1'b0;
			cpu_init_r <= 1'b1;
			periph_init_r <= 1'b1;
		end else begin
			irq_ack_r <= irq_take;
			cpu_init_r <= (state_nxt == ST_RESET) || double_fault;
			periph_init_r <= state_nxt == ST_RESET;
		end
	end

	// debug reset leaves the pins alone
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_pin_r <= 1'b0;
			state_pins_r <= 1'b1;
		end else begin
			rst_pin_r <= !pin_reset;
			state_pins_r <= pin_reset;
		end
	end

	assign status_word = sr_r;
	assign saved_pc = spc_r;
	assign saved_status = ssr_r;
	assign vector_base = vbr_r;
	assign exc_event_code = exc_event_code_r;
	assign irq_event_code = irq_event_code_r;
	assign irq_event_code_b = irq_event_code_b_r;
	assign fault_address = tea_r;
	assign page_entry_high = page_entry_high_r;
	assign way_replace_count = rc_r;
	assign new_pc = new_pc_r;
	assign pc_load = pc_load_r;
	assign irq_ack = irq_ack_r;
	assign cpu_init = cpu_init_r;
	assign periph_init = periph_init_r;
	assign reset_output_pin = rst_pin_r;
	assign cpu_state_pin_0 = state_pins_r;
	assign cpu_state_pin_1 = state_pins_r;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	por_abort_a: assert property (
		lk.por_hold |=> state_r == ST_RESET)
		else $error("power-on reset did not enter reset state");
	man_wait_a: assert property (
		$rose(lk.man_hold) |-> !$past(mem_access_busy))
		else $error("manual reset began during a memory access");
	entry_bits_a: assert property ((exc_ok || irq_take) |=>
		sr_r[SR_MD_BIT] && sr_r[SR_BL_BIT] && sr_r[SR_RB_BIT])
		else $error("entry did not set status bits");
	reset_vec_a: assert property (reset_done |=> pc_load &&
		new_pc == RESET_VECTOR
		&& exc_event_code == reset_code($past(kind_r)))
		else $error("reset vector or code wrong");
	reset_init_a: assert property (state_r == ST_RESET |=>
		vector_base == VBR_RESET && sr_r[SR_IMASK_LO+:IMASK_W] == IMASK_INIT)
		else $error("reset did not initialise vector base or mask");
	pin_level_a: assert property (pin_reset |=>
		!reset_output_pin && cpu_state_pin_0 && cpu_state_pin_1)
		else $error("reset pin levels wrong");
	irq_entry_a: assert property (irq_take |=> irq_ack &&
		saved_pc == $past(current_pc) && irq_event_code == $past(irq_code)
		&& irq_event_code_b == irq_event_code
		&& new_pc == $past(vbr_r) + OFS_IRQ)
		else $error("interrupt entry wrong");
	irq_boundary_a: assert property (
		irq_ack |-> $past(insn_done))
		else $error("interrupt taken mid instruction");
	miss_entry_a: assert property (exc_ok && lk.tlb_miss |=>
		new_pc == $past(vbr_r) + OFS_TLB_MISS
		&& fault_address == $past(mmu_vaddr))
		else $error("tlb miss entry wrong");
	miss_count_a: assert property (
		exc_ok && lk.tlb_miss && (&mmu_ways_valid)
		|=> way_replace_count == $past(rc_r) + 1'b1)
		else $error("way count not incremented");
	double_fault_a: assert property (double_fault |=>
		pc_load && new_pc == RESET_VECTOR && cpu_init)
		else $error("held exception did not reset cpu");
	one_seq_a: assert property (pc_load |-> !$past(pc_load))
		else $error("two sequences back to back");
endmodule : cpu_exception_sequencer

// *** logic/exc_seq_pkg.sv ***
/*
 exception sequencer constants: vectors, event codes, status word layout,
 reset values, permission codes and sequencer enumerations.
 assumes a 32-bit address space and 12-bit event codes.
*/
package exc_seq_pkg;
	typedef logic [31:0] word_t;
	localparam int EVT_W = 12;
	typedef logic [EVT_W-1:0] evt_t;
	localparam int ASID_W = 8;

	localparam word_t RESET_VECTOR = 32'ha000_0000;
	localparam word_t OFS_GENERAL = 32'h0000_0100;
	localparam word_t OFS_TLB_MISS = 32'h0000_0400;
	localparam word_t OFS_IRQ = 32'h0000_0600;
	localparam word_t VBR_RESET = 32'h0000_0000;
	localparam word_t PAGE_ENTRY_HIGH_RESET = 32'h0000_0000;

	localparam evt_t CODE_POR = 12'h000;
	localparam evt_t CODE_MANUAL = 12'h020;
	localparam evt_t CODE_TLB_RD = 12'h040;
	localparam evt_t CODE_TLB_WR = 12'h060;
	localparam evt_t CODE_IPW = 12'h080;
	localparam evt_t CODE_PROT_RD = 12'h0a0;
	localparam evt_t CODE_PROT_WR = 12'h0c0;
	localparam evt_t EVT_RESET = 12'h000;

	localparam int SR_MD_BIT = 30;
	localparam int SR_RB_BIT = 29;
	localparam int SR_BL_BIT = 28;
	localparam int SR_IMASK_LO = 4;
	localparam int IMASK_W = 4;
	localparam logic [IMASK_W-1:0] IMASK_INIT = 4'hf;
	localparam word_t SR_ENTRY_SET = 32'h7000_0000;
	localparam word_t SR_RESET = 32'h7000_00f0;

	localparam int PAGE_ENTRY_HIGH_VPN_LO = 10;

	localparam logic [1:0] PERM_PRIV_RO = 2'h0;
	localparam logic [1:0] PERM_PRIV_RW = 2'h1;
	localparam logic [1:0] PERM_ALL_RO = 2'h2;

	typedef enum {ST_RUN, ST_RESET, ST_VECTOR} seq_state_t;
	typedef enum {RK_POR, RK_MANUAL, RK_DEBUG} rst_kind_t;
endpackage : exc_seq_pkg

// *** logic/exc_seq_link_if.sv ***
/*
 link between the sequencer and its reset sampler and mmu fault classifier.
 assumes all three sit on the same clock.
*/
`timescale 1ns/1ps
interface exc_seq_link_if #(parameter int WAYS = 4, parameter int RCW = 2) ();
	logic por_n, man_n, dbg_cmd, mem_busy;
	logic por_hold, man_hold, dbg_req;
	logic acc_valid, acc_write, acc_hit, acc_entry_valid, acc_dirty, priv;
	logic [1:0] acc_perm;
	logic [RCW-1:0] acc_way, rc_now, rc_nxt;
	logic [WAYS-1:0] ways_valid;
	logic fault, tlb_miss;
	logic [exc_seq_pkg::EVT_W-1:0] fault_code;

	modport seq (output por_n, man_n, dbg_cmd, mem_busy,
		output acc_valid, acc_write, acc_hit, acc_entry_valid, acc_dirty,
		output priv, acc_perm, acc_way, rc_now, ways_valid,
		input por_hold, man_hold, dbg_req, fault, tlb_miss, fault_code, rc_nxt);
	modport rst_side (input por_n, man_n, dbg_cmd, mem_busy,
		output por_hold, man_hold, dbg_req);
	modport mmu_side (input acc_valid, acc_write, acc_hit, acc_entry_valid,
		input acc_dirty, priv, acc_perm, acc_way, rc_now, ways_valid,
		output fault, tlb_miss, fault_code, rc_nxt);
endinterface : exc_seq_link_if

// *** logic/reset_pin_sampler.sv ***
/*
 samples the reset pins and the debug reset command each clock.
 assumes pins and mem_busy are synchronous to clk.
*/
`timescale 1ns/1ps
module reset_pin_sampler (
	input logic clk,
	input logic rst,
	exc_seq_link_if.rst_side lk
);
	logic por_hold_r, man_hold_r, dbg_req_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			por_hold_r <= 1'b0;
			dbg_req_r <= 1'b0;
		end else begin
			por_hold_r <= !lk.por_n;
			dbg_req_r <= lk.dbg_cmd;
		end
	end

	// manual reset waits for the bus to go quiet, then holds while low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			man_hold_r <= 1'b0;
		end else if (lk.man_n) begin
			man_hold_r <= 1'b0;
		end else if (!lk.mem_busy) begin
			man_hold_r <= 1'b1;
		end
	end

	assign lk.por_hold = por_hold_r;
	assign lk.man_hold = man_hold_r;
	assign lk.dbg_req = dbg_req_r;
endmodule : reset_pin_sampler

// *** logic/mmu_fault_classifier.sv ***
/*
 classifies one mmu access into miss, invalid, protection or initial
 page write, and picks the event code and next way-replacement value.
 assumes access info is valid in the cycle acc_valid is high.
*/
`timescale 1ns/1ps
module mmu_fault_classifier #(parameter int WAYS = 4, parameter int RCW = 2) (
	exc_seq_link_if.mmu_side lk
);
	import exc_seq_pkg::*;

	logic prot, miss, inval, pviol, ipw;

	function automatic logic [RCW-1:0] first_invalid(input logic [WAYS-1:0] v);
		logic [RCW-1:0] w;
		w = '0;
		for (int i = WAYS - 1; i >= 0; i--) begin
			if (!v[i]) begin
				w = RCW'(i);
			end
		end
		return w;
	endfunction : first_invalid

	always_comb begin
		case (lk.acc_perm)
			PERM_PRIV_RO: prot = !lk.priv || lk.acc_write;
			PERM_PRIV_RW: prot = !lk.priv;
			PERM_ALL_RO: prot = lk.acc_write;
			default: prot = 1'b0;
		endcase
	end

	assign miss = lk.acc_valid && !lk.acc_hit;
	assign inval = lk.acc_valid && lk.acc_hit
		&& !lk.acc_entry_valid;
	assign pviol = lk.acc_valid && lk.acc_hit && lk.acc_entry_valid && prot;
	assign ipw = lk.acc_valid && lk.acc_hit && lk.acc_entry_valid && !prot
		&& lk.acc_write && !lk.acc_dirty;

	assign lk.fault = miss || inval || pviol || ipw;
	assign lk.tlb_miss = miss;

	always_comb begin
		if (miss || inval) begin
			lk.fault_code = lk.acc_write ? CODE_TLB_WR : CODE_TLB_RD;
		end else if (pviol) begin
			lk.fault_code = lk.acc_write ? CODE_PROT_WR : CODE_PROT_RD;
		end else begin
			lk.fault_code = CODE_IPW;
		end
	end

	// miss: bump when all ways full, else lowest invalid way
	always_comb begin
		if (!miss) begin
			lk.rc_nxt = lk.acc_way;
		end else if (&lk.ways_valid) begin
			lk.rc_nxt = lk.rc_now + 1'b1;
		end else begin
			lk.rc_nxt = first_invalid(lk.ways_valid);
		end
	end
endmodule : mmu_fault_classifier

// *** tb/pipe_model.sv ***
/*
 pipeline stand-in: presents the pc to be saved and instruction ends.
 assumes the sequencer pulses pc_load for one cycle with new_pc valid.
*/
`timescale 1ns/1ps
module pipe_model (
	input logic clk,
	input logic rst,
	input logic stall,
	input logic pc_load,
	input exc_seq_pkg::word_t new_pc,
	output exc_seq_pkg::word_t current_pc,
	output logic insn_done
);
	import exc_seq_pkg::*;
	// no boundary while stalled, so a held request must wait
	assign insn_done = !stall && !rst;
	// pc moves only on a load, so the value to save is always known
	always @(negedge clk or posedge rst) begin
		if (rst)
			current_pc <= 32'h8c00_1000;
		else if (pc_load)
			current_pc <= new_pc ^ 32'h0000_0010;
	end
endmodule : pipe_model

// *** tb/tb_cpu_exception_sequencer.sv ***
/*
 self-checking bench of the exception sequencer, random and corner cases.
 assumes pipe_model for the pipeline and drives all else at falling edges.
*/
`timescale 1ns/1ps
module tb_cpu_exception_sequencer;
	import exc_seq_pkg::*;
	logic clk, rst, power_on_reset_n, manual_reset_n, debug_reset_cmd;
	logic mem_access_busy, insn_done, irq_req, irq_is_nmi, nmi_override;
	logic mmu_access_valid, mmu_write, mmu_hit, mmu_entry_valid;
	logic mmu_entry_dirty, sw_status_we, sw_vbr_we, sw_asid_we, stall;
	logic pc_load, irq_ack, cpu_init, periph_init, reset_output_pin;
	logic cpu_state_pin_0, cpu_state_pin_1, lo_seen, seen;
	word_t current_pc, mmu_vaddr, sw_status_data, sw_vbr_data, status_word;
	word_t saved_pc, saved_status, vector_base, fault_address, new_pc;
	word_t page_entry_high, e_sr, e_vbr, pc0;
	evt_t irq_code, exc_event_code, irq_event_code, irq_event_code_b, e_code;
	logic [1:0] mmu_hit_way, mmu_entry_perm, way_replace_count, e_rc;
	logic [3:0] mmu_ways_valid;
	logic [7:0] sw_asid_data, e_asid;
	int num_errors, cmp_count, seed, i;

	cpu_exception_sequencer dut (.clk, .rst, .power_on_reset_n,
		.manual_reset_n, .debug_reset_cmd, .mem_access_busy, .insn_done,
		.current_pc, .irq_req, .irq_is_nmi, .irq_code, .nmi_override,
		.mmu_access_valid, .mmu_write, .mmu_vaddr, .mmu_hit, .mmu_hit_way,
		.mmu_entry_valid, .mmu_entry_dirty, .mmu_entry_perm, .mmu_ways_valid,
		.sw_status_we, .sw_status_data, .sw_vbr_we, .sw_vbr_data,
		.sw_asid_we, .sw_asid_data, .status_word, .saved_pc, .saved_status,
		.vector_base, .exc_event_code, .irq_event_code, .irq_event_code_b,
		.fault_address, .page_entry_high, .way_replace_count, .new_pc,
		.pc_load, .irq_ack, .cpu_init, .periph_init, .reset_output_pin,
		.cpu_state_pin_0, .cpu_state_pin_1);
	pipe_model pm (.clk, .rst, .stall, .pc_load, .new_pc, .current_pc,
		.insn_done);

	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end

	task automatic check(input string what, input logic [31:0] seen_v, exp);
		cmp_count++;
		if (seen_v !== exp) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", what, exp, seen_v);
		end
	endtask : check

	task automatic give_verdict();
		$display("counts: %0d compares, %0d mismatches", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict

	task automatic tick();
		@(negedge clk);
	endtask : tick

	// bounded wait for the branch pulse, noting any reset pin activity
	task automatic wait_load(input int lim);
		int n;
		n = 0;
		while (pc_load !== 1'b1 && n < lim) begin
			tick();
			lo_seen |= !reset_output_pin;
			n++;
		end
	endtask : wait_load

	task automatic quiet();
		seen = 0;
		repeat (4) begin
			tick();
			seen |= irq_ack | pc_load;
		end
	endtask : quiet

	task automatic set_sw(input word_t sr, vb);
		sw_status_we = 1;
		sw_status_data = sr;
		sw_vbr_we = 1;
		sw_vbr_data = vb;
		sw_asid_we = 1;
		sw_asid_data = vb[7:0];
		tick();
		sw_status_we = 0;
		sw_vbr_we = 0;
		sw_asid_we = 0;
		e_sr = sr;
		e_vbr = vb;
		e_asid = vb[7:0];
		tick();
	endtask : set_sw

	function automatic logic [1:0] low_inv(input logic [3:0] wv);
		for (int k = 3; k >= 0; k--)
			if (!wv[k])
				low_inv = 2'(k);
	endfunction : low_inv

	task automatic do_rst(input int k);
		lo_seen = 0;
		if (k == 2) begin
			debug_reset_cmd = 1;
			tick();
			debug_reset_cmd = 0;
		end else begin
			if (k == 1) begin
				mem_access_busy = 1;
				manual_reset_n = 0;
				repeat (4) wait_load(1);
				check("early reset pin", lo_seen, 0);
				mem_access_busy = 0;
			end else
				power_on_reset_n = 0;
			repeat (4) tick();
			check("reset pin", reset_output_pin, 0);
			check("state pins", {cpu_state_pin_1, cpu_state_pin_0}, 3);
			check("init", {cpu_init, periph_init}, 3);
			power_on_reset_n = 1;
			manual_reset_n = 1;
		end
		wait_load(8);
		check("reset target", new_pc, RESET_VECTOR);
		e_code = (k == 1) ? CODE_MANUAL : CODE_POR;
		check("reset code", exc_event_code, e_code);
		check("reset status", status_word, SR_RESET);
		check("reset vbr", vector_base, VBR_RESET);
		if (k == 2)
			check("debug pin", lo_seen, 0);
		e_sr = SR_RESET;
		e_vbr = VBR_RESET;
		repeat (2) tick();
	endtask : do_rst

	task automatic take_irq();
		stall = 0;
		pc0 = current_pc;
		wait_load(6);
		check("irq ack", irq_ack, 1);
		check("irq target", new_pc, e_vbr + OFS_IRQ);
		check("irq code", irq_event_code, irq_code);
		check("irq code b", irq_event_code_b, irq_code);
		check("irq spc", saved_pc, pc0);
		check("irq ssr", saved_status, e_sr);
		check("irq sr", status_word, e_sr | SR_ENTRY_SET);
		irq_req = 0;
		e_sr |= SR_ENTRY_SET;
		repeat (2) tick();
	endtask : take_irq

	task automatic do_fault(input logic w, h, v, d, input logic [1:0] pm_v,
			wy, input logic [3:0] wv, input word_t va);
		logic viol, miss, inv, prot, ipw, flt, dbl;
		evt_t c;
		logic [1:0] r;
		viol = (!e_sr[SR_MD_BIT] && !pm_v[1]) || (w && !pm_v[0]);
		miss = !h;
		inv = h && !v;
		prot = h && v && viol;
		ipw = h && v && !viol && w && !d;
		flt = miss || inv || prot || ipw;
		dbl = e_sr[SR_BL_BIT];
		c = prot ? (w ? CODE_PROT_WR : CODE_PROT_RD) : CODE_IPW;
		if (miss || inv)
			c = w ? CODE_TLB_WR : CODE_TLB_RD;
		r = miss ? (&wv ? e_rc + 2'h1 : low_inv(wv)) : wy;
		pc0 = current_pc;
		mmu_access_valid = 1;
		mmu_write = w;
		mmu_hit = h;
		mmu_entry_valid = v;
		mmu_entry_dirty = d;
		mmu_entry_perm = pm_v;
		mmu_hit_way = wy;
		mmu_ways_valid = wv;
		mmu_vaddr = va;
		tick();
		mmu_access_valid = 0;
		wait_load(4);
		check("fault taken", pc_load, flt);
		if (flt && dbl) begin
			check("dbl target", new_pc, RESET_VECTOR);
			check("dbl init", cpu_init, 1);
			check("dbl sr", status_word, SR_RESET);
			check("dbl vbr", vector_base, VBR_RESET);
			check("dbl code", exc_event_code, e_code);
			e_sr = SR_RESET;
			e_vbr = VBR_RESET;
		end else if (flt) begin
			check("no irq ack", irq_ack, 0);
			check("target", new_pc,
				e_vbr + (miss ? OFS_TLB_MISS : OFS_GENERAL));
			check("code", exc_event_code, c);
			check("spc", saved_pc, pc0);
			check("ssr", saved_status, e_sr);
			check("sr", status_word, e_sr | SR_ENTRY_SET);
			check("tea", fault_address, va);
			check("vpn", page_entry_high[31:10], va[31:10]);
			check("asid", page_entry_high[7:0], e_asid);
			check("way", way_replace_count, r);
			e_sr |= SR_ENTRY_SET;
			e_code = c;
			e_rc = r;
		end
		repeat (2) tick();
	endtask : do_fault

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		give_verdict();
	end

	initial begin
		seed = 74;
		{debug_reset_cmd, mem_access_busy, irq_req, irq_is_nmi} = 0;
		{nmi_override, mmu_access_valid, mmu_write, mmu_hit} = 0;
		{mmu_entry_valid, mmu_entry_dirty, sw_status_we, sw_vbr_we} = 0;
		{sw_asid_we, mmu_hit_way, mmu_entry_perm, mmu_ways_valid} = 0;
		{irq_code, mmu_vaddr, sw_status_data, sw_vbr_data, sw_asid_data} = 0;
		{power_on_reset_n, manual_reset_n, stall, rst} = 4'hf;
		repeat (5) @(posedge clk);
		tick();
		rst = 0;
		wait_load(6);
		check("boot target", new_pc, RESET_VECTOR);
		repeat (2) tick();
		for (i = 0; i < 3; i++) begin
			set_sw(32'h4000_0030, 32'h0bad_0000 + i);
			do_rst(i);
		end
		$display("test resets done");
		set_sw(32'h4000_00a0, word_t'($random(seed)));
		irq_req = 1;
		irq_code = evt_t'($random(seed));
		quiet();
		check("stalled irq", seen, 0);
		take_irq();
		set_sw(32'h5000_00f0, word_t'($random(seed)));
		irq_req = 1;
		quiet();
		check("held irq", seen, 0);
		irq_is_nmi = 1;
		quiet();
		check("held nmi", seen, 0);
		nmi_override = 1;
		take_irq();
		irq_is_nmi = 0;
		nmi_override = 0;
		$display("test interrupts done");
		do_fault(0, 0, 0, 0, 0, 0, 4'hf, 32'h1234_5678);
		$display("test double fault done");
		for (i = 0; i < 40; i++) begin
			set_sw(word_t'($random(seed)) & 32'h4000_00f0,
				word_t'($random(seed)));
			irq_req = (i == 1);
			// i 0 misses with way 3 free, i 1 with random valid ways, i 2 misses with every way full
			do_fault(1'($random(seed)), i > 2 && ($random(seed) & 3) != 0,
				($random(seed) & 3) != 0, 1'($random(seed)),
				2'($random(seed)), 2'($random(seed)),
				(i == 0) ? 4'h7 : (i == 2) ? 4'hf : 4'($random(seed)),
				word_t'($random(seed)));
			irq_req = 0;
		end
		$display("test mmu faults done");
		give_verdict();
	end
endmodule : tb_cpu_exception_sequencer
